// [hw/idx_pkg.sv]
// Shared constants for the indexer station command handshake.
// Assumes a single 50 MHz clock and an active-low asynchronous reset at both ends.
package idx_pkg;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned LEAD_TIME_MS = 4;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned LEAD_CYCLES = LEAD_TIME_MS * MS_CYCLES;
  localparam int unsigned START_PULSE_CYCLES = 4;

  // ==========================================================================
  // Parameter encodings.
  // ==========================================================================
  localparam logic [3:0] CTRL_MODE_INDEXER = 4'h1;
  localparam logic [7:0] MIN_STATIONS = 8'h02;

  // ==========================================================================
  // Master register map, byte addresses.
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATION = 8'h04;
  localparam logic [7:0] ADDR_SPEED = 8'h08;
  localparam logic [7:0] ADDR_GO = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int unsigned CTRL_ENERGIZE = 0;
  localparam int unsigned CTRL_DIR = 1;
  localparam int unsigned CTRL_SOURCE = 2;
  localparam int unsigned CTRL_MODE_A = 3;
  localparam int unsigned CTRL_MODE_B = 4;
  localparam logic [4:0] CTRL_RESET = 5'h10;

  // Master sequencer states; each step changes one bit except the return from pulse to idle.
  typedef enum logic [1:0] {
    IDX_H_IDLE = 2'h0,
    IDX_H_LEAD = 2'h1,
    IDX_H_PULSE = 2'h3
  } idx_host_state_e;

endpackage

// [hw/idx_link_if.sv]
// Cyclic bit and word link between the fieldbus master and the indexer drive.
// Assumes both ends share one clock; the bench joins them through this interface.
interface idx_link_if;

  // ==========================================================================
  // Master to drive.
  // ==========================================================================
  logic op_mode_select_a;
  logic op_mode_select_b;
  logic servo_energize_cmd;
  logic positioning_start_cmd;
  logic rotation_dir_cmd;
  logic [4:0] target_station_bits_low;
  logic [2:0] target_station_bits_high;
  logic [2:0] speed_profile_select;
  logic command_source_select;
  logic [15:0] target_station_word;
  logic [15:0] profile_or_speed_word;

  // ==========================================================================
  // Drive to master.
  // ==========================================================================
  logic at_position_flag;
  logic near_position_flag;
  logic move_done_flag;
  logic [7:0] reached_station_bits;

  modport master (
    output op_mode_select_a, op_mode_select_b, servo_energize_cmd, positioning_start_cmd,
    output rotation_dir_cmd, target_station_bits_low, target_station_bits_high,
    output speed_profile_select, command_source_select, target_station_word,
    output profile_or_speed_word,
    input at_position_flag, near_position_flag, move_done_flag, reached_station_bits
  );

  modport drive (
    input op_mode_select_a, op_mode_select_b, servo_energize_cmd, positioning_start_cmd,
    input rotation_dir_cmd, target_station_bits_low, target_station_bits_high,
    input speed_profile_select, command_source_select, target_station_word,
    input profile_or_speed_word,
    output at_position_flag, near_position_flag, move_done_flag, reached_station_bits
  );

endinterface

// [hw/idx_host.sv]
// Fieldbus master end: software registers drive the cyclic command bits.
// Assumes software on a plain strobe port; read data appear one cycle after the strobe.
module idx_host #(
  parameter int unsigned LEAD_CYCLES = idx_pkg::LEAD_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  idx_link_if.master link
);

  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (LEAD_CYCLES < 1) begin : g_bad_lead
    $error("LEAD_CYCLES must be at least one.");
  end

  typedef struct packed {
    idx_pkg::idx_host_state_e st;
    logic [4:0] ctrl;
    logic [7:0] station;
    logic [15:0] speed;
    logic [31:0] cnt;
    logic start;
    logic [31:0] rdata;
  } idx_host_s;

  idx_host_s s_q;
  idx_host_s s_d;
  logic busy;

  assign busy = (s_q.st != idx_pkg::IDX_H_IDLE);

  // Register writes, the start sequencer and the read mux.
  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0;
    if (wr && addr == idx_pkg::ADDR_CTRL) begin
      s_d.ctrl = wdata[4:0];
    end else if (wr && addr == idx_pkg::ADDR_STATION) begin
      s_d.station = wdata[7:0];
    end else if (wr && addr == idx_pkg::ADDR_SPEED) begin
      s_d.speed = wdata[15:0];
    end
    if (rd && addr == idx_pkg::ADDR_CTRL) begin
      s_d.rdata = {27'h0, s_q.ctrl};
    end else if (rd && addr == idx_pkg::ADDR_STATION) begin
      s_d.rdata = {24'h0, s_q.station};
    end else if (rd && addr == idx_pkg::ADDR_SPEED) begin
      s_d.rdata = {16'h0, s_q.speed};
    end else if (rd && addr == idx_pkg::ADDR_STATUS) begin
      s_d.rdata = {20'h0, link.reached_station_bits, busy, link.move_done_flag,
                   link.near_position_flag, link.at_position_flag};
    end
    case (s_q.st)
      idx_pkg::IDX_H_IDLE: begin
        // A go is dropped unless the previous move has reported done.
        if (wr && addr == idx_pkg::ADDR_GO && link.move_done_flag) begin
          s_d.st = idx_pkg::IDX_H_LEAD;
          s_d.cnt = 32'(LEAD_CYCLES - 1);
        end
      end
      idx_pkg::IDX_H_LEAD: begin
        // Selections already stand on the link; hold off start for the lead time.
        if (s_q.cnt == 32'h0) begin
          s_d.st = idx_pkg::IDX_H_PULSE;
          s_d.start = 1'b1;
          s_d.cnt = 32'(idx_pkg::START_PULSE_CYCLES - 1);
        end else begin
          s_d.cnt = s_q.cnt - 32'h1;
        end
      end
      idx_pkg::IDX_H_PULSE: begin
        if (s_q.cnt == 32'h0) begin
          s_d.st = idx_pkg::IDX_H_IDLE;
          s_d.start = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 32'h1;
        end
      end
      default: begin
        s_d.st = idx_pkg::IDX_H_IDLE;
        s_d.start = 1'b0;
      end
    endcase
  end

  // Single state register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: idx_pkg::IDX_H_IDLE, ctrl: idx_pkg::CTRL_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Link outputs come straight from the state register.
  assign rdata = s_q.rdata;
  assign link.op_mode_select_a = s_q.ctrl[idx_pkg::CTRL_MODE_A];
  assign link.op_mode_select_b = s_q.ctrl[idx_pkg::CTRL_MODE_B];
  assign link.servo_energize_cmd = s_q.ctrl[idx_pkg::CTRL_ENERGIZE];
  assign link.rotation_dir_cmd = s_q.ctrl[idx_pkg::CTRL_DIR];
  assign link.command_source_select = s_q.ctrl[idx_pkg::CTRL_SOURCE];
  assign link.positioning_start_cmd = s_q.start;
  assign link.target_station_bits_low = s_q.station[4:0];
  assign link.target_station_bits_high = s_q.station[7:5];
  assign link.speed_profile_select = s_q.speed[2:0];
  assign link.target_station_word = {8'h0, s_q.station};
  assign link.profile_or_speed_word = s_q.speed;

endmodule

// [hw/idx_drive.sv]
// Drive end of the indexer command handshake in fixed-rotation-direction mode.
// Assumes a servo loop on the user side that runs each accepted move and pulses arrival.
// Operation
// - Mode bits off/on select fixed-direction indexer.
// - Indexing only when control-mode digit is 1.
// - Source select bit chooses remote command words.
// - Remote words give station and speed data.
// - Speed parameter picks table or direct speed.
// - Station beyond count minus one raises warning.
// - Start during a running move is ignored.
// - Master starts only after move completion.
// - Speed select sampled only at start.
// - Master settles selections 4 ms before start.
// - Torque limit switches after delay past in-position.
// - Power-up in range asserts in-position.
// - Numbering direction parameter allocates stations.
// - Station count divides one revolution.
// - Count 0 to 2 means two stations.
// - Speed bits binary select table 1 to 8.
// - Motor turns in commanded rotation direction.
// - Start without homing raises home alarm.
//
// Added by the designer: the strobed register port and the placing of the registers.
module idx_drive #(
  parameter int unsigned MS_CYCLES = idx_pkg::MS_CYCLES,
  parameter bit TWO_STATIONS_OCCUPIED = 1'b1
) (
  input wire logic clock,
  input wire logic rstn,
  idx_link_if.drive link,
  input wire logic [15:0] control_mode_param,
  input wire logic speed_source_param,
  input wire logic [15:0] station_count_param,
  input wire logic station_numbering_dir_param,
  input wire logic [15:0] torque_switch_delay_param,
  input wire logic home_done,
  input wire logic in_range_at_power_up,
  input wire logic near_range,
  input wire logic move_arrived,
  output logic move_req,
  output logic [7:0] move_slot,
  output logic move_dir,
  output logic [2:0] move_table_idx,
  output logic move_direct_speed,
  output logic [15:0] move_speed,
  output logic post_torque_limit,
  output logic bad_station_warning,
  output logic home_not_done_alarm
);

  // ==========================================================================
  // Elaboration checks.
  // ==========================================================================
  if (MS_CYCLES < 1) begin : g_bad_ms
    $error("MS_CYCLES must be at least one.");
  end

  typedef struct packed {
    logic init;
    logic start_prev;
    logic busy;
    logic done;
    logic at_pos;
    logic near;
    logic [7:0] reached;
    logic [7:0] target;
    logic req;
    logic [7:0] slot;
    logic dir;
    logic [2:0] tbl;
    logic direct;
    logic [15:0] speed;
    logic torque_post;
    logic dly_run;
    logic [15:0] dly;
    logic [31:0] tick;
    logic warn;
    logic alarm;
  } idx_drive_s;

  idx_drive_s s_q;
  idx_drive_s s_d;

  // ==========================================================================
  // Command decode.
  // ==========================================================================

  // Station count: settings up to two give two stations, above that the low eight bits of the value.
  function automatic logic [7:0] idx_stations(input logic [15:0] p);
    if (p <= 16'(idx_pkg::MIN_STATIONS)) begin
      return idx_pkg::MIN_STATIONS;
    end
    return p[7:0];
  endfunction

  logic [7:0] n_st;
  logic [7:0] sel_station;
  logic mode_ok;
  logic start_rise;

  assign n_st = idx_stations(station_count_param);
  // Mode a off with mode b on, indexer digit set and servo energized.
  assign mode_ok = !link.op_mode_select_a && link.op_mode_select_b
                   && control_mode_param[15:12] == idx_pkg::CTRL_MODE_INDEXER
                   && link.servo_energize_cmd;
  // Remote word or discrete bits as the source of the target station.
  assign sel_station = link.command_source_select ? link.target_station_word[7:0]
                       : {link.target_station_bits_high, link.target_station_bits_low};
  assign start_rise = link.positioning_start_cmd && !s_q.start_prev;

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.start_prev = link.positioning_start_cmd;
    s_d.near = near_range;
    // Caught one clock after reset release, never through the reset itself.
    if (!s_q.init) begin
      s_d.init = 1'b1;
      s_d.at_pos = in_range_at_power_up;
      s_d.done = 1'b1;
    end
    // Start edges while a move runs, or outside indexer mode, are ignored.
    if (start_rise && mode_ok && !s_q.busy && s_q.init) begin
      if (!home_done) begin
        s_d.alarm = 1'b1;
      end else if (sel_station > n_st - 8'h01) begin
        s_d.warn = 1'b1;
      end else begin
        s_d.warn = 1'b0;
        s_d.alarm = 1'b0;
        s_d.busy = 1'b1;
        s_d.done = 1'b0;
        s_d.at_pos = 1'b0;
        s_d.torque_post = 1'b0;
        s_d.dly_run = 1'b0;
        s_d.req = 1'b1;
        s_d.target = sel_station;
        s_d.dir = link.rotation_dir_cmd;
        // Reverse numbering counts stations the other way round the circle.
        s_d.slot = (station_numbering_dir_param && sel_station != 8'h00)
                   ? n_st - sel_station : sel_station;
        // Speed data frozen here; later select changes cannot reach the move.
        s_d.direct = 1'b0;
        s_d.speed = 16'h0;
        if (link.command_source_select && speed_source_param) begin
          // Direct speed keeps acceleration from table entry 1.
          s_d.direct = 1'b1;
          s_d.tbl = 3'h0;
          s_d.speed = link.profile_or_speed_word;
        end else if (link.command_source_select) begin
          s_d.tbl = link.profile_or_speed_word[2:0] - 3'h1;
        end else if (TWO_STATIONS_OCCUPIED) begin
          s_d.tbl = link.speed_profile_select;
        end else begin
          s_d.tbl = 3'h0;
        end
      end
    end
    // Arrival closes the move and shows the reached station.
    if (s_q.busy && move_arrived) begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.at_pos = 1'b1;
      s_d.reached = s_q.target;
    end
    // In-position rise arms the torque switch delay in millisecond ticks.
    if (s_d.at_pos && !s_q.at_pos) begin
      s_d.dly_run = 1'b1;
      s_d.dly = torque_switch_delay_param;
      s_d.tick = 32'(MS_CYCLES - 1);
    end else if (s_q.dly_run) begin
      if (s_q.dly == 16'h0) begin
        s_d.dly_run = 1'b0;
        s_d.torque_post = s_q.at_pos;
      end else if (s_q.tick == 32'h0) begin
        s_d.tick = 32'(MS_CYCLES - 1);
        s_d.dly = s_q.dly - 16'h1;
      end else begin
        s_d.tick = s_q.tick - 32'h1;
      end
    end
  end

  // Single state register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all from the state register.
  // ==========================================================================
  assign link.at_position_flag = s_q.at_pos;
  assign link.near_position_flag = s_q.near;
  assign link.move_done_flag = s_q.done;
  assign link.reached_station_bits = s_q.reached;
  assign move_req = s_q.req;
  assign move_slot = s_q.slot;
  assign move_dir = s_q.dir;
  assign move_table_idx = s_q.tbl;
  assign move_direct_speed = s_q.direct;
  assign move_speed = s_q.speed;
  assign post_torque_limit = s_q.torque_post;
  assign bad_station_warning = s_q.warn;
  assign home_not_done_alarm = s_q.alarm;

endmodule

// [testbench/idx_link_monitor.sv]
// Concurrent checks on the link that joins the master end and the drive end.
// Assumes the bench wires it beside the shared link, on the one common clock.
module idx_link_monitor (
  input wire logic clock,
  input wire logic rstn,
  input wire logic op_mode_select_a,
  input wire logic op_mode_select_b,
  input wire logic servo_energize_cmd,
  input wire logic positioning_start_cmd,
  input wire logic [4:0] target_station_bits_low,
  input wire logic [2:0] target_station_bits_high,
  input wire logic [2:0] speed_profile_select,
  input wire logic at_position_flag,
  input wire logic move_done_flag,
  input wire logic [7:0] reached_station_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Sequences.
  // ==========================================================================
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence go_s;
    $rose(positioning_start_cmd);
  endsequence
  sequence fall_s;
    $fell(move_done_flag);
  endsequence

  // ==========================================================================
  // Assertions; a move may only begin one cycle after a start edge.
  // ==========================================================================
  done_by_start_a: assert property (
    fall_s |-> $past(positioning_start_cmd) && !$past(positioning_start_cmd, 2))
    else $error("done fell without start");
  mode_gate_a: assert property (
    fall_s |-> !$past(op_mode_select_a) && $past(op_mode_select_b)
    && $past(servo_energize_cmd)) else $error("move outside indexer mode");
  at_drop_a: assert property (
    $fell(at_position_flag) |-> $fell(move_done_flag)) else $error("at dropped alone");
  arrive_at_a: assert property (
    $rose(move_done_flag) && $past(rstn, 2) |-> at_position_flag) else $error("done without at");
  station_out_a: assert property (
    $changed(reached_station_bits) |-> $rose(move_done_flag)) else $error("station moved");
  start_gate_a: assert property (
    go_s |-> move_done_flag) else $error("start while busy");
  pulse_len_a: assert property (
    go_s |-> positioning_start_cmd [*4] ##1 !positioning_start_cmd) else $error("bad pulse");
  lead_hold_a: assert property (
    go_s |-> $past(speed_profile_select, 4) == speed_profile_select
    && $past(target_station_bits_low, 4) == target_station_bits_low
    && $past(target_station_bits_high, 4) == target_station_bits_high)
    else $error("selection moved in lead time");
endmodule

// [testbench/tb.sv]
// Self-checking bench joining the master end and the drive end through the link.
// Assumes shortened lead and millisecond counts so the run stays short.
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %0t %0h %0h", $time, (g), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] mode_p = 16'h1000;
  logic src_p = 1'b0;
  logic [15:0] count_p = 16'h0008;
  logic ndir_p = 1'b0;
  logic home = 1'b0;
  logic in_range = 1'b1;
  logic near = 1'b0;
  logic arrived = 1'b0;
  logic req, mdir, direct, torque, warn, alarm;
  logic [7:0] slot;
  logic [2:0] tbl;
  logic [15:0] speed;
  int mismatches = 0;
  int compares = 0;

  // ==========================================================================
  // Both ends and the checker; a 2 ms switch delay keeps torque waits short.
  // ==========================================================================
  idx_link_if link();
  idx_host #(.LEAD_CYCLES(8)) u_idx_host (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  idx_drive #(.MS_CYCLES(4), .TWO_STATIONS_OCCUPIED(1'b1)) u_idx_drive (.clock(clock),
    .rstn(rstn), .link(link), .control_mode_param(mode_p), .speed_source_param(src_p),
    .station_count_param(count_p), .station_numbering_dir_param(ndir_p),
    .torque_switch_delay_param(16'h0002), .home_done(home), .in_range_at_power_up(in_range),
    .near_range(near), .move_arrived(arrived), .move_req(req), .move_slot(slot),
    .move_dir(mdir), .move_table_idx(tbl), .move_direct_speed(direct), .move_speed(speed),
    .post_torque_limit(torque), .bad_station_warning(warn), .home_not_done_alarm(alarm));
  idx_link_monitor u_idx_link_monitor (.clock(clock), .rstn(rstn),
    .op_mode_select_a(link.op_mode_select_a), .op_mode_select_b(link.op_mode_select_b),
    .servo_energize_cmd(link.servo_energize_cmd),
    .positioning_start_cmd(link.positioning_start_cmd),
    .target_station_bits_low(link.target_station_bits_low),
    .target_station_bits_high(link.target_station_bits_high),
    .speed_profile_select(link.speed_profile_select),
    .at_position_flag(link.at_position_flag), .move_done_flag(link.move_done_flag),
    .reached_station_bits(link.reached_station_bits));

  // The 50 MHz clock.
  always #10 clock = ~clock;

  // ==========================================================================
  // Register port and move helpers.
  // ==========================================================================
  task automatic conclude();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just then.
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Program control, station and speed, then order a start and look for a move.
  task automatic go(input logic [4:0] c, input logic [7:0] st, input logic [15:0] sp,
                    input bit exp);
    bit seen;
    seen = 0;
    wreg(idx_pkg::ADDR_CTRL, {27'h0, c});
    wreg(idx_pkg::ADDR_STATION, {24'h0, st});
    wreg(idx_pkg::ADDR_SPEED, {16'h0, sp});
    wreg(idx_pkg::ADDR_GO, 32'h0);
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge clock);
      #1 seen = (req === 1'b1);
    end
    if (exp && !seen) begin
      mismatches++;
      conclude();
    end
    `CHK(seen, exp)
  endtask
  // Pulse arrival, then the flags, station outputs and torque switch must follow.
  task automatic land(input logic [7:0] st);
    logic [31:0] d;
    int n;
    @(posedge clock);
    arrived <= 1'b1;
    @(posedge clock);
    arrived <= 1'b0;
    @(posedge clock);
    #1;
    `CHK({link.move_done_flag, link.at_position_flag}, 2'h3)
    `CHK(link.reached_station_bits, st)
    for (n = 0; n < 30 && torque !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == 30) begin
      mismatches++;
      conclude();
    end
    // Two millisecond ticks of four cycles each, plus a little pipeline slack.
    `CHK(n >= 8 && n <= 10, 1'b1)
    rreg(idx_pkg::ADDR_STATUS, d);
    `CHK(d[11:4], st)
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_reset();
    logic [31:0] d;
    rreg(idx_pkg::ADDR_CTRL, d);
    `CHK(d, 32'h00000010)
    rreg(idx_pkg::ADDR_STATUS, d);
    `CHK(d[3:0], 4'h5)
    rreg(8'h20, d);
    `CHK(d, 32'h0)
  endtask
  task automatic t_discrete();
    go(5'h11, 8'h01, 16'h0000, 0);
    `CHK(alarm, 1'b1)
    @(posedge clock);
    home <= 1'b1;
    go(5'h13, 8'h03, 16'h0007, 1);
    `CHK({slot, mdir, tbl, torque}, {8'h03, 1'b1, 3'h7, 1'b0})
    wreg(idx_pkg::ADDR_SPEED, 32'h2);
    #1 `CHK(tbl, 3'h7)
    land(8'h03);
    `CHK(alarm, 1'b0)
  endtask
  task automatic t_reverse();
    @(posedge clock);
    ndir_p <= 1'b1;
    count_p <= 16'h0004;
    go(5'h11, 8'h01, 16'h0000, 1);
    `CHK({slot, mdir, tbl}, {8'h03, 1'b0, 3'h0})
    land(8'h01);
  endtask
  task automatic t_count();
    @(posedge clock);
    ndir_p <= 1'b0;
    count_p <= 16'h0000;
    go(5'h11, 8'h02, 16'h0000, 0);
    `CHK(warn, 1'b1)
    go(5'h11, 8'h01, 16'h0000, 1);
    land(8'h01);
    `CHK(warn, 1'b0)
    @(posedge clock);
    count_p <= 16'h00FF;
    go(5'h11, 8'hFF, 16'h0000, 0);
    `CHK(warn, 1'b1)
    go(5'h11, 8'hFE, 16'h0000, 1);
    land(8'hFE);
  endtask
  task automatic t_words();
    go(5'h15, 8'h02, 16'h0005, 1);
    `CHK({tbl, direct}, {3'h4, 1'b0})
    land(8'h02);
    @(posedge clock);
    src_p <= 1'b1;
    go(5'h15, 8'h03, 16'h1234, 1);
    `CHK({direct, speed, tbl}, {1'b1, 16'h1234, 3'h0})
    land(8'h03);
  endtask
  task automatic t_mode();
    go(5'h19, 8'h01, 16'h0000, 0);
    go(5'h10, 8'h01, 16'h0000, 0);
    @(posedge clock);
    mode_p <= 16'h2000;
    go(5'h11, 8'h01, 16'h0000, 0);
    `CHK({warn, alarm, link.move_done_flag}, 3'h1)
  endtask
  // Mid-run reset with the axis outside every in-position range and near a station.
  task automatic t_rereset();
    logic [31:0] d;
    @(posedge clock);
    in_range <= 1'b0;
    near <= 1'b1;
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    rreg(idx_pkg::ADDR_CTRL, d);
    `CHK(d, 32'h00000010)
    rreg(idx_pkg::ADDR_STATUS, d);
    `CHK(d, 32'h00000006)
  endtask

  // Main sequence, then the verdict; the watchdog cuts a hang short.
  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    t_reset();
    t_discrete();
    t_reverse();
    t_count();
    t_words();
    t_mode();
    t_rereset();
    conclude();
  end
  initial begin
    #1000000;
    mismatches++;
    conclude();
  end
endmodule
